//--- dv/dc_link_model.sv
// Voltage measurement model: one strobed sample per request
`timescale 1ns/1ps
module dc_link_model (
    input wire sys_clk, // System clock
    input wire rst_n, // Async reset, active low
    input wire req, // Take a sample next edge
    input wire [15:0] reqVolts, // Voltage to report
    output reg [15:0] dcLinkVolts, // Sample value
    output reg sampleStrobe // One-cycle sample strobe
);
    // Value is only valid with the strobe; it flips otherwise
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dcLinkVolts <= 16'h0000;
            sampleStrobe <= 1'b0;
        end else begin
            sampleStrobe <= req;
            dcLinkVolts <= req ? reqVolts : ~dcLinkVolts;
        end
    end
endmodule

//--- dv/dc_link_power_fail_bridge_props.sv
// Port-level assertions for the bridging controller
`timescale 1ns/1ps
module dc_link_power_fail_bridge_props (
    input wire sys_clk, // System clock
    input wire rst_n, // Async reset, active low
    input wire sampleStrobe, // New voltage sample
    input wire [15:0] dcLinkVolts, // Sampled voltage
    input wire [23:0] outFreq, // Commanded frequency
    input wire stageEnable, // Power stage enable
    input wire bridgeActive, // Bridging flag
    input wire [15:0] brakeRate // Braking rate
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    a_coast_freq_zero: assert property (
        !stageEnable |-> outFreq == 24'h000000)
        else $error("frequency not zero while stage off");
    a_cutoff_coast: assert property (
        sampleStrobe && bridgeActive && dcLinkVolts <= 16'h00B4
        |=> !stageEnable)
        else $error("stage still on below cutoff");
    a_brake_cap: assert property (brakeRate <= 16'h03E7)
        else $error("braking rate above limit");
    a_idle_no_brake: assert property (
        !bridgeActive |-> brakeRate == 16'h0000)
        else $error("braking rate outside bridging");
    a_active_on_sample: assert property (
        $changed(bridgeActive) |-> $past(sampleStrobe))
        else $error("bridging flag moved without a sample");
    a_stage_on_sample: assert property (
        $changed(stageEnable) |-> $past(sampleStrobe))
        else $error("stage enable moved without a sample");
    a_step_on_detect: assert property (
        $rose(bridgeActive) |-> outFreq == $past(outFreq) - 24'h0001F4)
        else $error("no frequency step on detection");
    // Above the highest settable threshold no failure may be seen
    a_high_no_detect: assert property (
        sampleStrobe && !bridgeActive && stageEnable &&
        dcLinkVolts > 16'h030E |=> !bridgeActive)
        else $error("failure declared above threshold");
endmodule
bind dc_link_power_fail_bridge dc_link_power_fail_bridge_props chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .sampleStrobe(sampleStrobe),
    .dcLinkVolts(dcLinkVolts), .outFreq(outFreq), .stageEnable(stageEnable),
    .bridgeActive(bridgeActive), .brakeRate(brakeRate));

//--- dv/tb.sv
// Self-checking bench for the bridging controller
`timescale 1ns/1ps
module tb;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h00000000;
    reg [15:0] reqVolts = 16'h0000, v;
    reg [23:0] freqRef = 24'h00C350;
    wire [31:0] prdata;
    wire pready, pslverr, sampleStrobe, stageEnable, bridgeActive;
    wire [15:0] dcLinkVolts, brakeRate;
    wire [23:0] outFreq;
    integer mismatches = 0, checked = 0, seed = 35, i, n;
    reg [65:0] expQ[$];
    reg [65:0] e;
    localparam [31:0] F = 32'hFFFFFFFF;
    always #25 sys_clk = ~sys_clk;
    dc_link_power_fail_bridge #(.MS_CYCLES(10)) uut (.sys_clk(sys_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dcLinkVolts(dcLinkVolts),
        .sampleStrobe(sampleStrobe), .freqRef(freqRef),
        .accelRate(16'h03E8), .chopperOnVolts(16'h0186), .outFreq(outFreq),
        .stageEnable(stageEnable), .bridgeActive(bridgeActive),
        .brakeRate(brakeRate));
    dc_link_model model (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
        .reqVolts(reqVolts), .dcLinkVolts(dcLinkVolts),
        .sampleStrobe(sampleStrobe));
    task report_and_stop;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task cmp_rd(input [32:0] got, input [65:0] ex);
        begin
            checked = checked + 1;
            if ((got & ex[65:33]) !== ex[32:0]) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t got %h exp %h", $time, got, ex[32:0]);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            n = 0;
            @(posedge sys_clk);
            while (pready !== 1'b1 && n < 20) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            if (n >= 20) begin
                mismatches = mismatches + 1;
                report_and_stop;
            end
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [32:0] ex, input [31:0] m);
        begin
            expQ.push_back({1'b1, m, ex});
            apb(1'b0, a, 32'h00000000);
        end
    endtask
    // Model strobes one edge after the request; design decides next edge
    task smp(input [15:0] x);
        begin
            @(posedge sys_clk);
            req <= 1'b1;
            reqVolts <= x;
            @(posedge sys_clk);
            req <= 1'b0;
            @(posedge sys_clk);
            @(negedge sys_clk);
        end
    endtask
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expQ.size() == 0) begin
                e = {33'h1FFFFFFFF, 33'h1FFFFFFFF};
            end else begin
                e = expQ.pop_front();
            end
            cmp_rd({pslverr, prdata}, e);
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h00, 33'h0, F);
        rd(8'h04, 33'h104, F);
        rd(8'h08, 33'hEC, F);
        rd(8'h0C, 33'h32, F);
        rd(8'h10, 33'h64, F);
        rd(8'h14, 33'h3E7, F);
        rd(8'h1C, 33'h20, 32'h33);
        rd(8'h20, {1'b1, 32'h0}, F);
        $display("test 1 done");
        for (i = 0; i < 6; i = i + 1) begin
            wr(8'h00, i);
            rd(8'h00, (i > 4) ? 33'h0 : {1'b0, i[31:0]}, F);
        end
        wr(8'h04, 32'h64);
        rd(8'h04, 33'hD4, F);
        wr(8'h04, 32'h1F4);
        rd(8'h04, 33'h198, F);
        wr(8'h0C, 32'h0);
        rd(8'h0C, 33'h1, F);
        wr(8'h0C, 32'h4E20);
        rd(8'h0C, 33'h2710, F);
        wr(8'h14, 32'h0);
        rd(8'h14, 33'h1, F);
        for (i = 0; i < 4; i = i + 1) begin
            v = 16'($random(seed)) & 16'h00FF;
            wr(8'h10, {16'h0000, v});
            rd(8'h10, (v > 16'hB4) ? 33'hB4 : {17'h0, v}, F);
        end
        wr(8'h0C, 32'h5);
        wr(8'h00, 32'h2);
        rd(8'h0C, 33'h32, F);
        rd(8'h14, 33'h3E7, F);
        wr(8'h18, 32'h1);
        rd(8'h04, 33'h1C4, F);
        rd(8'h08, 33'h1B6, F);
        wr(8'h18, 32'h0);
        rd(8'h04, 33'h104, F);
        for (i = 0; i < 4; i = i + 1) begin
            smp(16'h0310 + (16'($random(seed)) & 16'h00FF));
            cmp(bridgeActive, 32'h0);
        end
        $display("test 2 done");
        // Restart variant already selected; shorten the mains check interval to 2 ms
        wr(8'h0C, 32'h2);
        smp(16'h012C);
        cmp(bridgeActive, 32'h0);
        cmp(outFreq, 32'hC350);
        smp(16'h00FA);
        cmp(bridgeActive, 32'h1);
        cmp(outFreq <= 24'h00C15C, 32'h1);
        smp(16'h012C);
        rd(8'h1C, 33'h31, 32'h33);
        smp(16'h00C8);
        cmp(brakeRate, 32'hE1);
        wr(8'h10, 32'h32);
        smp(16'h00C8);
        cmp(brakeRate, 32'h70);
        wr(8'h14, 32'h64);
        wr(8'h10, 32'h64);
        smp(16'h00C8);
        cmp(brakeRate, 32'h64);
        repeat (30) @(posedge sys_clk);
        smp(16'h012C);
        rd(8'h1C, 33'h32, 32'h33);
        smp(16'h00FA);
        rd(8'h1C, 33'h31, 32'h33);
        for (i = 0; i < 60 && bridgeActive !== 1'b0; i = i + 1)
            smp(16'h012C);
        if (i >= 60) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
        cmp(outFreq, 32'hC350);
        $display("test 3 done");
        wr(8'h00, 32'h3);
        wr(8'h0C, 32'h1);
        smp(16'h00FA);
        repeat (30) @(posedge sys_clk);
        smp(16'h012C);
        rd(8'h1C, 33'h31, 32'h73);
        smp(16'h0096);
        cmp(stageEnable, 32'h0);
        cmp(outFreq, 32'h0);
        smp(16'h012C);
        cmp(stageEnable, 32'h1);
        $display("test 4 done");
        wr(8'h00, 32'h1);
        smp(16'h0064);
        cmp(bridgeActive, 32'h0);
        cmp(stageEnable, 32'h1);
        @(posedge sys_clk);
        freqRef <= 24'h002710;
        smp(16'h012C);
        wr(8'h00, 32'h4);
        smp(16'h00FA);
        smp(16'h00FA);
        cmp(brakeRate, 32'h3E7);
        for (i = 0; i < 60 && stageEnable !== 1'b0; i = i + 1)
            smp(16'h00FA);
        if (i >= 60) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
        cmp(stageEnable, 32'h0);
        cmp(outFreq, 32'h0);
        $display("test 5 done");
        report_and_stop;
    end
endmodule

//--- hw/dc_link_power_fail_bridge.v
// DC-link power failure bridging controller with APB registers
//
// How it works
// - Type codes 0..4, reset to off
// - Detect threshold clamped per voltage class
// - Regulate DC link to reference after failure
// - Mains check interval 1 to 10000 ms
// - Current reference 0 to 180 percent
// - Decel limit caps commanded braking rate
// - Failure when voltage below threshold
// - No mains check without restart variant
// - Reference above threshold makes bridging toggle
// - Braking rate follows voltage error dynamically, except fixed at decel limit in fastest variant
// - Frequency step down on failure detection
// - Undervoltage cutoff disables power stage while bridging only
// - Restart variant checks mains each interval
// - Mains return accelerates to frequency reference
// - Fastest variant brakes at decel limit, so its target above chopper voltage goes unused
// - Fastest variant stops stage at 2 Hz
// - Type write presets other parameters
// - Current reference scales braking steepness
`timescale 1ns/1ps
`include "pf_bridge_regs.vh"
module dc_link_power_fail_bridge #(
    parameter MS_CYCLES = `PF_MS_CYCLES
) (
    input wire sys_clk, // System clock, 20 MHz
    input wire rst_n, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error, unmapped address
    input wire [15:0] dcLinkVolts, // DC-link voltage sample, volts
    input wire sampleStrobe, // New voltage sample, one cycle
    input wire [23:0] freqRef, // Frequency reference, mHz
    input wire [15:0] accelRate, // Profile accel ramp, Hz/s
    input wire [15:0] chopperOnVolts, // Chopper turn-on voltage
    output reg [23:0] outFreq, // Commanded output frequency, mHz
    output reg stageEnable, // Power stage enabled
    output reg bridgeActive, // Bridging in progress
    output reg [15:0] brakeRate // Current braking rate, Hz/s
);
    localparam ST_IDLE = 2'd0;
    localparam ST_BRIDGE = 2'd1;
    localparam ST_ACCEL = 2'd2;
    localparam ST_COAST = 2'd3;

    reg [15:0] bridgingType;
    reg [15:0] detectThreshold;
    reg [15:0] regulationRef;
    reg [15:0] checkInterval;
    reg [15:0] currentRef;
    reg [15:0] decelLimit;
    reg highClass;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] next_brakeRate;
    reg consumeCheck;
    wire msTick;
    wire checkDue;
    wire access;
    wire wrStrobe;
    wire enabled;
    wire isRestart;
    wire isFastest;
    wire [15:0] voltMin;
    wire [15:0] voltMax;
    wire [15:0] uvCutoff;
    wire [15:0] chopTarget;
    wire [15:0] target;
    wire [16:0] err;
    wire [31:0] scaled;
    wire [15:0] dynRate;

    function [15:0] clampVal;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < lo)
                clampVal = lo;
            else if (v > hi)
                clampVal = hi;
            else
                clampVal = v;
        end
    endfunction

    // APB: one wait state, so data and errors come from flops
    assign access = psel && penable && !pready;
    assign wrStrobe = psel && penable && pready && pwrite;

    assign voltMin = highClass ? `PF_VOLT_HI_MIN : `PF_VOLT_LO_MIN;
    assign voltMax = highClass ? `PF_VOLT_HI_MAX : `PF_VOLT_LO_MAX;
    assign uvCutoff = highClass ? `PF_UV_CUTOFF_HI : `PF_UV_CUTOFF_LO;

    assign enabled = bridgingType == `PF_TYPE_RESTART ||
        bridgingType == `PF_TYPE_NORESTART ||
        bridgingType == `PF_TYPE_FASTEST;
    assign isRestart = bridgingType == `PF_TYPE_RESTART;
    assign isFastest = bridgingType == `PF_TYPE_FASTEST;

    assign chopTarget = chopperOnVolts + `PF_CHOP_MARGIN;
    // Fastest target never sits below the chopper turn-on level
    assign target = (isFastest && regulationRef < chopTarget) ?
        chopTarget : regulationRef;
    assign err = {1'b0, target} - {1'b0, dcLinkVolts};
    // Gain of 1/16 per percent keeps the product in 32 bits
    assign scaled = err[16] ? 32'h00000000 :
        ({16'h0000, err[15:0]} * {16'h0000, currentRef}) >> 4;
    assign dynRate = (scaled > {16'h0000, decelLimit}) ?
        decelLimit : scaled[15:0];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (access) begin
                case (paddr)
                    `PF_OFS_TYPE: prdata <= {16'h0000, bridgingType};
                    `PF_OFS_THRESH: prdata <= {16'h0000, detectThreshold};
                    `PF_OFS_REF: prdata <= {16'h0000, regulationRef};
                    `PF_OFS_INTERVAL: prdata <= {16'h0000, checkInterval};
                    `PF_OFS_CURRENT: prdata <= {16'h0000, currentRef};
                    `PF_OFS_DECEL: prdata <= {16'h0000, decelLimit};
                    `PF_OFS_CONFIG: prdata <= {31'h0, highClass};
                    `PF_OFS_STATUS: prdata <= {25'h0, checkDue,
                        stageEnable, bridgeActive, 2'b00, state};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Register writes take effect at the completing edge only
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bridgingType <= `PF_RST_TYPE;
            detectThreshold <= `PF_THRESH_LO_DEF;
            regulationRef <= `PF_REF_LO_DEF;
            checkInterval <= `PF_RST_INTERVAL;
            currentRef <= `PF_RST_CURRENT;
            decelLimit <= `PF_RST_DECEL;
            highClass <= 1'b0;
        end else if (wrStrobe) begin
            case (paddr)
                `PF_OFS_TYPE: begin
                    // Out-of-range codes fall back to off
                    if (pwdata[15:0] > `PF_TYPE_FASTEST)
                        bridgingType <= `PF_TYPE_OFF;
                    else
                        bridgingType <= pwdata[15:0];
                    detectThreshold <= highClass ?
                        `PF_THRESH_HI_DEF : `PF_THRESH_LO_DEF;
                    regulationRef <= highClass ?
                        `PF_REF_HI_DEF : `PF_REF_LO_DEF;
                    checkInterval <= `PF_RST_INTERVAL;
                    currentRef <= `PF_RST_CURRENT;
                    decelLimit <= `PF_RST_DECEL;
                end
                `PF_OFS_THRESH: detectThreshold <=
                    clampVal(pwdata[15:0], voltMin, voltMax);
                `PF_OFS_REF: regulationRef <=
                    clampVal(pwdata[15:0], voltMin, voltMax);
                `PF_OFS_INTERVAL: checkInterval <= clampVal(pwdata[15:0],
                    `PF_INTERVAL_MIN, `PF_INTERVAL_MAX);
                `PF_OFS_CURRENT: currentRef <= clampVal(pwdata[15:0],
                    16'h0000, `PF_CURRENT_MAX);
                `PF_OFS_DECEL: decelLimit <= clampVal(pwdata[15:0],
                    `PF_DECEL_MIN, `PF_DECEL_MAX);
                `PF_OFS_CONFIG: begin
                    // Class change re-presets the voltages to stay in range
                    highClass <= pwdata[`PF_CFG_CLASS_BIT];
                    detectThreshold <= pwdata[`PF_CFG_CLASS_BIT] ?
                        `PF_THRESH_HI_DEF : `PF_THRESH_LO_DEF;
                    regulationRef <= pwdata[`PF_CFG_CLASS_BIT] ?
                        `PF_REF_HI_DEF : `PF_REF_LO_DEF;
                end
                default: highClass <= highClass;
            endcase
        end
    end

    // Check timer runs only while bridging in the restart variant
    pf_interval_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(state == ST_BRIDGE && isRestart),
        .interval(checkInterval),
        .consume(consumeCheck),
        .msTick(msTick),
        .checkDue(checkDue)
    );

    // State decisions only on a fresh sample
    always @* begin
        next_state = state;
        next_brakeRate = brakeRate;
        consumeCheck = 1'b0;
        if (sampleStrobe) begin
            case (state)
                ST_IDLE: begin
                    if (enabled && dcLinkVolts < detectThreshold)
                        next_state = ST_BRIDGE;
                end
                ST_BRIDGE: begin
                    next_brakeRate = isFastest ? decelLimit : dynRate;
                    if (dcLinkVolts <= uvCutoff)
                        next_state = ST_COAST;
                    else if (isFastest && outFreq <= `PF_STOP_FREQ)
                        next_state = ST_COAST;
                    else if (isRestart && checkDue) begin
                        consumeCheck = 1'b1;
                        // A reference above threshold lands here each time
                        if (dcLinkVolts >= detectThreshold)
                            next_state = ST_ACCEL;
                    end
                end
                ST_ACCEL: begin
                    next_brakeRate = 16'h0000;
                    if (dcLinkVolts <= uvCutoff)
                        next_state = ST_COAST;
                    else if (dcLinkVolts < detectThreshold)
                        next_state = ST_BRIDGE;
                    else if (outFreq >= freqRef)
                        next_state = ST_IDLE;
                end
                ST_COAST: begin
                    next_brakeRate = 16'h0000;
                    // Leaves coast only with mains clearly back
                    if (dcLinkVolts >= detectThreshold)
                        next_state = ST_IDLE;
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            brakeRate <= 16'h0000;
            bridgeActive <= 1'b0;
            stageEnable <= 1'b1;
        end else begin
            state <= next_state;
            // A rate left over on leaving bridge would mislead the stage
            brakeRate <= (next_state == ST_BRIDGE) ?
                next_brakeRate : 16'h0000;
            bridgeActive <= next_state == ST_BRIDGE ||
                next_state == ST_ACCEL;
            stageEnable <= next_state != ST_COAST;
        end
    end

    // Frequency path: Hz/s equals mHz per ms tick
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outFreq <= 24'h000000;
        end else if (next_state == ST_COAST) begin
            // Zero together with the stage disable, never a cycle late
            outFreq <= 24'h000000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (next_state == ST_BRIDGE)
                        outFreq <= (outFreq > `PF_FREQ_STEP) ?
                            outFreq - `PF_FREQ_STEP : 24'h000000;
                    else
                        outFreq <= freqRef;
                end
                ST_BRIDGE: begin
                    if (msTick)
                        outFreq <= (outFreq > {8'h00, brakeRate}) ?
                            outFreq - {8'h00, brakeRate} :
                            24'h000000;
                end
                ST_ACCEL: begin
                    if (msTick) begin
                        if (outFreq + {8'h00, accelRate} >= freqRef)
                            outFreq <= freqRef;
                        else
                            outFreq <= outFreq + {8'h00, accelRate};
                    end
                end
                ST_COAST: outFreq <= 24'h000000;
                default: outFreq <= 24'h000000;
            endcase
        end
    end
endmodule

//--- hw/pf_bridge_regs.vh
// Register map, field layout, presets and timing for the bridging block
`ifndef PF_BRIDGE_REGS_VH
`define PF_BRIDGE_REGS_VH

// Byte offsets on the APB bus
`define PF_OFS_TYPE 8'h00
`define PF_OFS_THRESH 8'h04
`define PF_OFS_REF 8'h08
`define PF_OFS_INTERVAL 8'h0C
`define PF_OFS_CURRENT 8'h10
`define PF_OFS_DECEL 8'h14
`define PF_OFS_CONFIG 8'h18
`define PF_OFS_STATUS 8'h1C

// Config field: device voltage class
`define PF_CFG_CLASS_BIT 0

// Status fields
`define PF_ST_STATE_LSB 0
`define PF_ST_ACTIVE_BIT 4
`define PF_ST_STAGE_BIT 5
`define PF_ST_CHECKDUE_BIT 6

// Bridging type codes
`define PF_TYPE_OFF 16'h0000
`define PF_TYPE_NOFUNC 16'h0001
`define PF_TYPE_RESTART 16'h0002
`define PF_TYPE_NORESTART 16'h0003
`define PF_TYPE_FASTEST 16'h0004

// Reset values and presets
`define PF_RST_TYPE 16'h0000
`define PF_THRESH_LO_DEF 16'h0104
`define PF_THRESH_HI_DEF 16'h01C4
`define PF_REF_LO_DEF 16'h00EC
`define PF_REF_HI_DEF 16'h01B6
`define PF_RST_INTERVAL 16'h0032
`define PF_RST_CURRENT 16'h0064
`define PF_RST_DECEL 16'h03E7

// Ranges
`define PF_VOLT_LO_MIN 16'h00D4
`define PF_VOLT_LO_MAX 16'h0198
`define PF_VOLT_HI_MIN 16'h01A9
`define PF_VOLT_HI_MAX 16'h030E
`define PF_INTERVAL_MIN 16'h0001
`define PF_INTERVAL_MAX 16'h2710
`define PF_CURRENT_MAX 16'h00B4
`define PF_DECEL_MIN 16'h0001
`define PF_DECEL_MAX 16'h03E7

// Fixed undervoltage cutoff per class, volts
`define PF_UV_CUTOFF_LO 16'h00B4
`define PF_UV_CUTOFF_HI 16'h0168
// Target margin above chopper turn-on, volts
`define PF_CHOP_MARGIN 16'h000A
// Frequency step on detection and stop limit, mHz
`define PF_FREQ_STEP 24'h0001F4
`define PF_STOP_FREQ 24'h0007D0

// Timing: one millisecond tick at 50 ns clock
`define PF_TICK_NS 1000000
`define PF_CLK_PERIOD_NS 50
`define PF_MS_CYCLES (`PF_TICK_NS / `PF_CLK_PERIOD_NS)

`endif

//--- hw/pf_interval_timer.v
// Millisecond tick and mains-check interval timer
`timescale 1ns/1ps
module pf_interval_timer #(
    parameter MS_CYCLES = 20000
) (
    input wire sys_clk, // System clock
    input wire rst_n, // Async reset, active low
    input wire run, // Interval count runs while high; msTick runs always
    input wire [15:0] interval, // Check interval in ms
    input wire consume, // Clears checkDue
    output reg msTick, // One-cycle pulse per ms
    output reg checkDue // Interval elapsed, level
);
    reg [15:0] cycCount;
    reg [15:0] msCount;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cycCount <= 16'h0000;
            msTick <= 1'b0;
        end else if (cycCount == MS_CYCLES[15:0] - 16'h0001) begin
            cycCount <= 16'h0000;
            msTick <= 1'b1;
        end else begin
            cycCount <= cycCount + 16'h0001;
            msTick <= 1'b0;
        end
    end

    // Set wins over consume so a due check is never lost
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            msCount <= 16'h0000;
            checkDue <= 1'b0;
        end else if (!run) begin
            msCount <= 16'h0000;
            checkDue <= 1'b0;
        end else if (msTick && msCount + 16'h0001 >= interval) begin
            msCount <= 16'h0000;
            checkDue <= 1'b1;
        end else begin
            if (msTick)
                msCount <= msCount + 16'h0001;
            if (consume)
                checkDue <= 1'b0;
        end
    end
endmodule
